//--- shared/sar_map.svh
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
// Start-up hold of the fault output, 2 s at 100 MHz
`define SAR_CLK_HZ 100000000
`define SAR_INIT_TIME_MS 2000
`define SAR_INIT_CYCLES ((`SAR_CLK_HZ / 1000) * `SAR_INIT_TIME_MS)
// Alarm code bit order {bit3,bit2,bit1}
`define SAR_CODE_NONE 3'h0
`define SAR_CODE_CONFIG 3'h0
`define SAR_CODE_OVERCUR 3'h1
`define SAR_CODE_OVERFLOW 3'h3
`define SAR_CODE_OVERVOLT 3'h4
`define SAR_CODE_OVERSPD 3'h5
`define SAR_CODE_OVERLOAD 3'h7
`define SAR_CODE_WIRING 3'h5
`define SAR_CODE_PWRLOSS 3'h2
// Serial detail identifiers
`define SAR_ID_NONE 8'h00
`define SAR_ID_ABSDATA 8'h01
`define SAR_ID_PARAM 8'h02
`define SAR_ID_OVERCUR 8'h10
`define SAR_ID_OVERFLOW 8'h31
`define SAR_ID_OVERVOLT 8'h40
`define SAR_ID_OVERSPD 8'h51
`define SAR_ID_OVERLOAD 8'h71
`define SAR_ID_WIRING 8'hC2
`define SAR_ID_ENCALM 8'h80
`define SAR_ID_PWRLOSS 8'hF3
`define SAR_HIST_DEPTH 8
`endif

//--- shared/sar_pkg.sv
package sar_pkg;
	typedef struct packed {
		logic absolute_data_fault;
		logic parameter_fault;
		logic overcurrent_fault;
		logic error_counter_overflow_fault;
		logic overvoltage_fault;
		logic overspeed_fault;
		logic overload_fault;
		logic encoder_wiring_fault;
		logic encoder_alarm_fault;
		logic power_loss_fault;
	} sar_faults_t;

	typedef struct packed {
		logic [2:0] code;
		logic [7:0] id;
	} sar_alarm_t;

	typedef enum logic [1:0] {
		SAR_INIT,
		SAR_RUN,
		SAR_ALARM
	} sar_state_t;
endpackage

//--- logic/sar_encode.sv
`timescale 1ns/10ps
`include "sar_map.svh"
module sar_encode
	import sar_pkg::*;
(
	input wire sar_faults_t faults,
	output logic any_fault,
	output sar_alarm_t alarm
);
	// Fixed priority, first match wins
	always_comb begin
		any_fault = |faults;
		alarm = '{code: `SAR_CODE_NONE, id: `SAR_ID_NONE};
		if (faults.absolute_data_fault) begin
			alarm = '{code: `SAR_CODE_CONFIG, id: `SAR_ID_ABSDATA};
		end else if (faults.parameter_fault) begin
			alarm = '{code: `SAR_CODE_CONFIG, id: `SAR_ID_PARAM};
		end else if (faults.encoder_alarm_fault) begin
			alarm = '{code: `SAR_CODE_CONFIG, id: `SAR_ID_ENCALM};
		end else if (faults.overcurrent_fault) begin
			alarm = '{code: `SAR_CODE_OVERCUR, id: `SAR_ID_OVERCUR};
		end else if (faults.overvoltage_fault) begin
			alarm = '{code: `SAR_CODE_OVERVOLT, id: `SAR_ID_OVERVOLT};
		end else if (faults.overload_fault) begin
			alarm = '{code: `SAR_CODE_OVERLOAD, id: `SAR_ID_OVERLOAD};
		end else if (faults.overspeed_fault) begin
			alarm = '{code: `SAR_CODE_OVERSPD, id: `SAR_ID_OVERSPD};
		end else if (faults.encoder_wiring_fault) begin
			alarm = '{code: `SAR_CODE_WIRING, id: `SAR_ID_WIRING};
		end else if (faults.error_counter_overflow_fault) begin
			alarm = '{code: `SAR_CODE_OVERFLOW, id: `SAR_ID_OVERFLOW};
		end else if (faults.power_loss_fault) begin
			alarm = '{code: `SAR_CODE_PWRLOSS, id: `SAR_ID_PWRLOSS};
		end
	end
endmodule

//--- logic/sar_history.sv
`timescale 1ns/10ps
`include "sar_map.svh"
module sar_history
	import sar_pkg::*;
#(
	parameter int DEPTH = `SAR_HIST_DEPTH,
	parameter int AW = $clog2(`SAR_HIST_DEPTH)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic push,
	input wire logic [7:0] push_id,
	input wire logic [AW-1:0] rd_index,
	output logic [7:0] rd_id,
	output logic [AW:0] count
);
	logic [7:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] nxt_wr;
	logic [AW:0] cnt_ff;
	logic [AW:0] nxt_cnt;

	always_comb begin
		nxt_wr = wr_ff;
		nxt_cnt = cnt_ff;
		if (push) begin
			nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			if (cnt_ff != (AW+1)'(DEPTH)) begin
				nxt_cnt = cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			cnt_ff <= nxt_cnt;
		end
	end

	// Ring of past alarm ids, index 0 is newest
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= push_id;
		end
	end

	logic [AW-1:0] rd_slot;
	always_comb begin
		rd_slot = AW'((int'(wr_ff) + DEPTH - 1 - int'(rd_index)) % DEPTH);
		rd_id = (AW+1)'(rd_index) < cnt_ff ? mem_ff[rd_slot] : `SAR_ID_NONE;
	end
	assign count = cnt_ff;
endmodule

//--- logic/sar_top.sv
`timescale 1ns/10ps
`include "sar_map.svh"
module sar_top
	import sar_pkg::*;
#(
	parameter int INIT_CYCLES = `SAR_INIT_CYCLES,
	parameter int HIST_DEPTH = `SAR_HIST_DEPTH,
	parameter int HAW = $clog2(`SAR_HIST_DEPTH)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire sar_faults_t faults_in,
	input wire logic servo_on_in,
	input wire logic servo_disable_command,
	input wire logic power_present_in,
	input wire logic fault_clear_command,
	input wire logic alarm_reset_in,
	input wire logic absolute_encoder_sel,
	input wire logic [HAW-1:0] hist_rd_index,
	output logic alarm_code_bit1,
	output logic alarm_code_bit2,
	output logic alarm_code_bit3,
	output logic servo_fault_output,
	output logic power_drive_enable,
	output logic dynamic_brake_req,
	output logic green_led,
	output logic red_led,
	output logic report_valid,
	output logic [7:0] report_id,
	output logic [7:0] hist_rd_id,
	output logic [HAW:0] hist_count
);
	// Pin synchronisers
	sar_faults_t flt_s1_ff, flt_s2_ff;
	logic [5:0] pin_s1_ff, pin_s2_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flt_s1_ff <= '0;
			flt_s2_ff <= '0;
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end else begin
			flt_s1_ff <= faults_in;
			flt_s2_ff <= flt_s1_ff;
			pin_s1_ff <= {servo_on_in, servo_disable_command, power_present_in,
				fault_clear_command, alarm_reset_in, absolute_encoder_sel};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	logic servo_on, svc_off, powered, clr_cmd, rst_in, abs_sel;
	assign {servo_on, svc_off, powered, clr_cmd, rst_in, abs_sel} = pin_s2_ff;

	logic any_fault;
	sar_alarm_t cur_alarm;
	sar_encode u_encode (
		.faults(flt_s2_ff),
		.any_fault(any_fault),
		.alarm(cur_alarm)
	);

	// Power-up counter width
	localparam int CW = $clog2(INIT_CYCLES + 1);

	sar_state_t state_ff, nxt_state;
	logic [CW-1:0] init_cnt_ff, nxt_init_cnt;
	sar_alarm_t lat_ff, nxt_lat;
	logic clr_d_ff, rst_d_ff;
	logic [7:0] hist_id_raw;
	logic clr_edge, rst_edge, clear_req, push;

	always_comb begin
		clr_edge = clr_cmd & ~clr_d_ff;
		rst_edge = rst_in & ~rst_d_ff;
		clear_req = clr_edge | (rst_edge & abs_sel);
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_init_cnt = init_cnt_ff;
		nxt_lat = lat_ff;
		push = 1'b0;
		unique case (state_ff)
			SAR_INIT: begin
				if (init_cnt_ff == CW'(INIT_CYCLES)) begin
					nxt_state = SAR_RUN;
				end else begin
					nxt_init_cnt = init_cnt_ff + 1'b1;
				end
			end
			SAR_RUN: begin
				if (any_fault) begin
					nxt_state = SAR_ALARM;
					nxt_lat = cur_alarm;
					push = 1'b1;
				end
			end
			SAR_ALARM: begin
				// Clear only once the cause is gone; new faults stay latched out
				if (clear_req && !any_fault) begin
					nxt_state = SAR_RUN;
					nxt_lat = '0;
				end
			end
		endcase
		// Unpowered holds start-up at zero so the hold restarts on return
		if (!powered) begin
			nxt_state = SAR_INIT;
			nxt_init_cnt = '0;
			nxt_lat = '0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= SAR_INIT;
			init_cnt_ff <= '0;
			lat_ff <= '0;
			clr_d_ff <= 1'b0;
			rst_d_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			init_cnt_ff <= nxt_init_cnt;
			lat_ff <= nxt_lat;
			clr_d_ff <= clr_cmd;
			rst_d_ff <= rst_in;
		end
	end

	// Outputs, all registered; all but green_led and hist_rd_id from the next-state view
	logic nxt_alarm, nxt_ok;
	always_comb begin
		nxt_alarm = (nxt_state == SAR_ALARM);
		nxt_ok = (nxt_state == SAR_RUN) && powered;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm_code_bit1 <= 1'b0;
			alarm_code_bit2 <= 1'b0;
			alarm_code_bit3 <= 1'b0;
			servo_fault_output <= 1'b0;
			power_drive_enable <= 1'b0;
			dynamic_brake_req <= 1'b1;
			green_led <= 1'b0;
			red_led <= 1'b0;
			report_valid <= 1'b0;
			report_id <= `SAR_ID_NONE;
			hist_rd_id <= `SAR_ID_NONE;
		end else begin
			// High drives the open-collector transistor on
			{alarm_code_bit3, alarm_code_bit2, alarm_code_bit1} <= nxt_lat.code;
			servo_fault_output <= nxt_ok;
			power_drive_enable <= nxt_ok && servo_on && !svc_off;
			dynamic_brake_req <= !(nxt_ok && servo_on && !svc_off);
			green_led <= powered;
			red_led <= nxt_alarm;
			report_valid <= push;
			report_id <= nxt_lat.id;
			hist_rd_id <= hist_id_raw;
		end
	end

	sar_history #(
		.DEPTH(HIST_DEPTH),
		.AW(HAW)
	) u_hist (
		.clk(clk),
		.nrst(nrst),
		.push(push),
		.push_id(cur_alarm.id),
		.rd_index(hist_rd_index),
		.rd_id(hist_id_raw),
		.count(hist_count)
	);
endmodule

//--- dv/sar_props.sv
`timescale 1ns/10ps
module sar_props
	import sar_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire sar_faults_t faults_in,
	input wire logic power_present_in,
	input wire logic alarm_code_bit1,
	input wire logic alarm_code_bit2,
	input wire logic alarm_code_bit3,
	input wire logic servo_fault_output,
	input wire logic power_drive_enable,
	input wire logic dynamic_brake_req,
	input wire logic green_led,
	input wire logic red_led,
	input wire logic report_valid,
	input wire logic [7:0] report_id
);
	logic [2:0] code;
	assign code = {alarm_code_bit3, alarm_code_bit2, alarm_code_bit1};
	function automatic logic [2:0] exp_code(logic [7:0] id);
		case (id)
			8'h10: return 3'h1;
			8'h31: return 3'h3;
			8'h40: return 3'h4;
			8'h51, 8'hC2: return 3'h5;
			8'h71: return 3'h7;
			8'hF3: return 3'h2;
			default: return 3'h0;
		endcase
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_brake_alarm:
		assert property (red_led |-> dynamic_brake_req) else $error("brake off in alarm");
	a_drive_off:
		assert property (red_led |-> !power_drive_enable && !servo_fault_output)
		else $error("drive on in alarm");
	a_code_map:
		assert property (red_led |-> code == exp_code(report_id)) else $error("code wrong");
	a_report_pulse:
		assert property (report_valid |=> !report_valid) else $error("report too long");
	a_code_instant:
		assert property ($rose(red_led) |-> report_valid && $past(servo_fault_output))
		else $error("code not with output drop");
	a_latch_hold:
		assert property (red_led ##1 red_led |-> $stable(report_id) && $stable(code))
		else $error("latched alarm changed");
	a_fault_react:
		assert property ($rose(faults_in.overcurrent_fault) && servo_fault_output && !red_led
			|-> ##[1:4] red_led) else $error("fault not latched");
	a_green_power:
		assert property (power_present_in [*4] |-> green_led) else $error("green off");
	a_clear_normal:
		assert property ($fell(red_led) && power_present_in |-> servo_fault_output)
		else $error("clear not normal");
	cover property ($rose(red_led));
	cover property ($fell(red_led));
	cover property (report_valid && report_id == 8'h71);
endmodule

//--- dv/sar_host.sv
`timescale 1ns/10ps
module sar_host (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clr_req,
	output logic fault_clear_command
);
	logic [2:0] cnt_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 3'h0;
		end else if (clr_req && cnt_ff == 3'h0) begin
			cnt_ff <= 3'h4;
		end else if (cnt_ff != 3'h0) begin
			cnt_ff <= cnt_ff - 3'h1;
		end
	end
	// Held past the sync stage
	assign fault_clear_command = (cnt_ff != 3'h0);
endmodule

//--- dv/sar_top_tb.sv
`timescale 1ns/10ps
module sar_top_tb
	import sar_pkg::*;
;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	sar_faults_t faults_in = '0;
	logic servo_on_in = 1'h1, servo_disable_command = 1'h0, power_present_in = 1'h1;
	logic alarm_reset_in = 1'h0, absolute_encoder_sel = 1'h0, clr_req = 1'h0;
	logic [2:0] hist_rd_index = 3'h0;
	logic fault_clear_command, alarm_code_bit1, alarm_code_bit2, alarm_code_bit3;
	logic servo_fault_output, power_drive_enable, dynamic_brake_req, green_led, red_led;
	logic report_valid;
	logic [7:0] report_id, hist_rd_id;
	logic [3:0] hist_count;
	int bad_count = 0, check_count = 0, cyc = 0;
	logic [2:0] ecode [10] = '{3'h2, 3'h0, 3'h5, 3'h7, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0, 3'h0};
	logic [7:0] eid [10] = '{8'hF3, 8'h80, 8'hC2, 8'h71, 8'h51, 8'h40, 8'h31, 8'h10, 8'h02, 8'h01};
	sar_top #(.INIT_CYCLES(20)) DUT (.clk, .nrst, .faults_in, .servo_on_in,
		.servo_disable_command, .power_present_in, .fault_clear_command, .alarm_reset_in,
		.absolute_encoder_sel, .hist_rd_index, .alarm_code_bit1, .alarm_code_bit2,
		.alarm_code_bit3, .servo_fault_output, .power_drive_enable, .dynamic_brake_req,
		.green_led, .red_led, .report_valid, .report_id, .hist_rd_id, .hist_count);
	sar_host u_host (.clk, .nrst, .clr_req, .fault_clear_command);
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_red(logic v);
		repeat (12) if (red_led !== v) tick(1);
	endtask
	task automatic host_clear;
		@(posedge clk);
		clr_req <= 1'h1;
		@(posedge clk);
		clr_req <= 1'h0;
	endtask
	task automatic t_init;
		tick(10);
		chk("sfo", 1'h0, servo_fault_output);
		tick(20);
		chk("sfo", 1'h1, servo_fault_output);
		chk("green", 1'h1, green_led);
	endtask
	task automatic t_codes;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			faults_in <= sar_faults_t'(10'h1 << i);
			wait_red(1'h1);
			chk("red", 1'h1, red_led);
			chk("code", ecode[i], {alarm_code_bit3, alarm_code_bit2, alarm_code_bit1});
			chk("id", eid[i], report_id);
			chk("brake", 1'h1, dynamic_brake_req);
			@(posedge clk);
			faults_in <= '0;
			host_clear();
			wait_red(1'h0);
			chk("sfo", 1'h1, servo_fault_output);
			tick(4);
		end
		chk("hist_count", 8'h08, hist_count);
		chk("hist_id", 8'h01, hist_rd_id);
		@(posedge clk);
		hist_rd_index <= 3'h7;
		tick(2);
		chk("hist_old", 8'hC2, hist_rd_id);
	endtask
	task automatic t_first;
		@(posedge clk);
		faults_in.overcurrent_fault <= 1'h1;
		wait_red(1'h1);
		@(posedge clk);
		faults_in.overvoltage_fault <= 1'h1;
		host_clear();
		tick(8);
		chk("id", 8'h10, report_id);
		chk("red", 1'h1, red_led);
		@(posedge clk);
		faults_in <= '0;
		alarm_reset_in <= 1'h1;
		tick(8);
		chk("red", 1'h1, red_led);
		@(posedge clk);
		alarm_reset_in <= 1'h0;
		absolute_encoder_sel <= 1'h1;
		@(posedge clk);
		alarm_reset_in <= 1'h1;
		wait_red(1'h0);
		chk("red", 1'h0, red_led);
	endtask
	task automatic t_brake;
		chk("brake", 1'h0, dynamic_brake_req);
		chk("drive", 1'h1, power_drive_enable);
		@(posedge clk);
		servo_disable_command <= 1'h1;
		tick(5);
		chk("brake", 1'h1, dynamic_brake_req);
		@(posedge clk);
		servo_disable_command <= 1'h0;
		servo_on_in <= 1'h0;
		tick(5);
		chk("brake", 1'h1, dynamic_brake_req);
		@(posedge clk);
		servo_on_in <= 1'h1;
		power_present_in <= 1'h0;
		tick(5);
		chk("brake", 1'h1, dynamic_brake_req);
		chk("green", 1'h0, green_led);
		@(posedge clk);
		power_present_in <= 1'h1;
		tick(8);
		chk("sfo", 1'h0, servo_fault_output);
		tick(25);
		chk("sfo", 1'h1, servo_fault_output);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		t_init();
		t_codes();
		t_first();
		t_brake();
		complete_run();
	end
endmodule
bind sar_top sar_props u_props (.clk, .nrst, .faults_in, .power_present_in,
	.alarm_code_bit1, .alarm_code_bit2, .alarm_code_bit3, .servo_fault_output,
	.power_drive_enable, .dynamic_brake_req, .green_led, .red_led, .report_valid, .report_id);
